// ===== pkg/acr_pkg.sv
// constants and types for the converter configuration register block
//
// Operation
// - input pair select picks differential or single-ended
// - gain range decoded, codes above 100 give 0.256
// - mode bit 0 continuous, 1 single-shot powerdown
// - sample rate codes 000-110, 111 unused; code times 111 like 110 at 3300 SPS
// - temp sense bit routes internal sensor
// - pull-up only while chip select high, enabled
// - write only when qualifier equals 01
// - constant-level input never updates register
// - reserved bit 0 ignored, host writes 1
// - qualifier field resets to 01
// - bit 15 starts single shot when idle
// - clock idles low, sample on falling edges
// - shift config in while result shifts out
package acr_pkg;
    // ---------------------------------------------------------------
    // register layout
    // ---------------------------------------------------------------
    localparam int unsigned CFG_W        = 16;
    localparam int unsigned BIT_START    = 15;
    localparam int unsigned MUX_HI       = 14;
    localparam int unsigned MUX_LO       = 12;
    localparam int unsigned GAIN_HI      = 11;
    localparam int unsigned GAIN_LO      = 9;
    localparam int unsigned BIT_MODE     = 8;
    localparam int unsigned RATE_HI      = 7;
    localparam int unsigned RATE_LO      = 5;
    localparam int unsigned BIT_TSENSE   = 4;
    localparam int unsigned BIT_PULLUP   = 3;
    localparam int unsigned QUAL_HI      = 2;
    localparam int unsigned QUAL_LO      = 1;
    localparam logic [15:0] CFG_RESET    = 16'h058b;
    localparam logic [1:0]  QUAL_VALID   = 2'h1;
    localparam logic [2:0]  GAIN_MAX     = 3'h5;
    localparam logic [2:0]  RATE_UNUSED  = 3'h7;
    localparam logic [2:0]  MUX_SE_BASE  = 3'h4;
    localparam logic [4:0]  FRAME_BITS   = 5'h10;
    localparam logic [4:0]  BITCNT_W0    = 5'h00;
    // ---------------------------------------------------------------
    // conversion timing (cycles of the core clock at 200 MHz)
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned RATE_SPS_0   = 128;
    localparam int unsigned RATE_SPS_1   = 250;
    localparam int unsigned RATE_SPS_2   = 490;
    localparam int unsigned RATE_SPS_3   = 920;
    localparam int unsigned RATE_SPS_4   = 1600;
    localparam int unsigned RATE_SPS_5   = 2400;
    localparam int unsigned RATE_SPS_6   = 3300;
    localparam int unsigned CNV_W        = 21;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0] input_pair;
        logic [2:0] gain_range_select;
        logic       single_shot_mode;
        logic [2:0] sample_rate_select;
        logic       temp_sense_select;
        logic       pullup_enable;
    } acr_ctrl_t;

    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic       din;
    } acr_link_t;

    typedef enum logic [1:0] {
        CNV_IDLE,
        CNV_RUN
    } acr_cnv_state_t;
endpackage

// ===== hw/acr_sync.sv
// two-flop synchroniser for link pins
`timescale 1ns/10ps
module acr_sync #(
    parameter int unsigned  W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // start at the pins' idle levels
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ===== hw/acr_top.sv
// converter configuration register with serial link shifter
`timescale 1ns/10ps
module acr_top (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        DIN,
    input  wire logic [11:0] RESULT_DATA,
    output logic             DATA_OUT_READY_N_O,
    output logic             DATA_OUT_READY_N_OE_N,
    output logic             PULLUP_ON,
    output logic [2:0]       INPUT_PAIR,
    output logic [1:0]       POSITIVE_INPUT,
    output logic [2:0]       NEGATIVE_INPUT,
    output logic [2:0]       GAIN_RANGE_SELECT,
    output logic             CONTINUOUS_MODE,
    output logic             POWERED_DOWN,
    output logic [2:0]       SAMPLE_RATE_SELECT,
    output logic             TEMP_SENSE_SELECT,
    output logic             CONVERSION_START,
    output logic             RESULT_READY,
    output logic [15:0]      CONFIG_READBACK
);
    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    acr_pkg::acr_link_t link_raw;
    acr_pkg::acr_link_t link_s;

    assign link_raw = '{sclk: SCLK, cs_n: CS_N, din: DIN};

    // cs_n starts high so the pin stays released as reset lifts
    acr_sync #(
        .W       ($bits(acr_pkg::acr_link_t)),
        .RST_VAL (3'h2)
    ) u_sync (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .d     (link_raw),
        .q     (link_s)
    );

    logic sclk_d_reg;
    logic sclk_rise;
    logic sclk_fall;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= link_s.sclk;
        end
    end

    assign sclk_fall = sclk_d_reg & ~link_s.sclk & ~link_s.cs_n;
    assign sclk_rise = ~sclk_d_reg & link_s.sclk & ~link_s.cs_n;

    // ---------------------------------------------------------------
    // configuration register
    // ---------------------------------------------------------------
    acr_pkg::acr_ctrl_t ctrl_reg;
    logic [1:0]         qual_reg;
    logic               resv_reg;
    logic [15:0]        shift_in_reg;
    logic [15:0]        shift_in_next;
    logic [4:0]         bitcnt_reg;
    logic               word_done;
    logic               word_ok;
    logic               cnv_busy;

    assign shift_in_next = {shift_in_reg[14:0], link_s.din};
    assign word_done = sclk_fall && (bitcnt_reg == acr_pkg::FRAME_BITS - 5'h01);
    // all-zero and all-one words give 00 or 11 and are refused
    assign word_ok = word_done &&
        (shift_in_next[acr_pkg::QUAL_HI:acr_pkg::QUAL_LO] == acr_pkg::QUAL_VALID);

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bitcnt_reg <= acr_pkg::BITCNT_W0;
        end else if (link_s.cs_n) begin
            bitcnt_reg <= acr_pkg::BITCNT_W0;
        end else if (sclk_fall) begin
            if (bitcnt_reg == 5'h1f) begin
                bitcnt_reg <= acr_pkg::BITCNT_W0;
            end else begin
                bitcnt_reg <= bitcnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            shift_in_reg <= '0;
        end else if (sclk_fall) begin
            shift_in_reg <= shift_in_next;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg.input_pair         <= acr_pkg::CFG_RESET[acr_pkg::MUX_HI:acr_pkg::MUX_LO];
            ctrl_reg.gain_range_select  <= acr_pkg::CFG_RESET[acr_pkg::GAIN_HI:acr_pkg::GAIN_LO];
            ctrl_reg.single_shot_mode   <= acr_pkg::CFG_RESET[acr_pkg::BIT_MODE];
            ctrl_reg.sample_rate_select <= acr_pkg::CFG_RESET[acr_pkg::RATE_HI:acr_pkg::RATE_LO];
            ctrl_reg.temp_sense_select  <= acr_pkg::CFG_RESET[acr_pkg::BIT_TSENSE];
            ctrl_reg.pullup_enable      <= acr_pkg::CFG_RESET[acr_pkg::BIT_PULLUP];
            qual_reg                    <= acr_pkg::CFG_RESET[acr_pkg::QUAL_HI:acr_pkg::QUAL_LO];
        end else if (word_ok) begin
            ctrl_reg.input_pair         <= shift_in_next[acr_pkg::MUX_HI:acr_pkg::MUX_LO];
            ctrl_reg.gain_range_select  <= shift_in_next[acr_pkg::GAIN_HI:acr_pkg::GAIN_LO];
            ctrl_reg.single_shot_mode   <= shift_in_next[acr_pkg::BIT_MODE];
            ctrl_reg.sample_rate_select <= shift_in_next[acr_pkg::RATE_HI:acr_pkg::RATE_LO];
            ctrl_reg.temp_sense_select  <= shift_in_next[acr_pkg::BIT_TSENSE];
            ctrl_reg.pullup_enable      <= shift_in_next[acr_pkg::BIT_PULLUP];
            qual_reg                    <= shift_in_next[acr_pkg::QUAL_HI:acr_pkg::QUAL_LO];
        end
    end

    // reserved bit stored for readback only
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            resv_reg <= acr_pkg::CFG_RESET[0];
        end else if (word_ok) begin
            resv_reg <= shift_in_next[0];
        end
    end

    // ---------------------------------------------------------------
    // conversion sequencing
    // ---------------------------------------------------------------
    acr_pkg::acr_cnv_state_t cnv_state_reg;
    logic [acr_pkg::CNV_W-1:0] cnv_cnt_reg;
    logic [acr_pkg::CNV_W-1:0] cnv_len;
    logic                      ss_request;
    logic                      new_data_reg;

    always_comb begin
        case (ctrl_reg.sample_rate_select)
            3'h0:    cnv_len = acr_pkg::CNV_W'(acr_pkg::CLK_HZ / acr_pkg::RATE_SPS_0);
            3'h1:    cnv_len = acr_pkg::CNV_W'(acr_pkg::CLK_HZ / acr_pkg::RATE_SPS_1);
            3'h2:    cnv_len = acr_pkg::CNV_W'(acr_pkg::CLK_HZ / acr_pkg::RATE_SPS_2);
            3'h3:    cnv_len = acr_pkg::CNV_W'(acr_pkg::CLK_HZ / acr_pkg::RATE_SPS_3);
            3'h4:    cnv_len = acr_pkg::CNV_W'(acr_pkg::CLK_HZ / acr_pkg::RATE_SPS_4);
            3'h5:    cnv_len = acr_pkg::CNV_W'(acr_pkg::CLK_HZ / acr_pkg::RATE_SPS_5);
            3'h6:    cnv_len = acr_pkg::CNV_W'(acr_pkg::CLK_HZ / acr_pkg::RATE_SPS_6);
            default: cnv_len = acr_pkg::CNV_W'(acr_pkg::CLK_HZ / acr_pkg::RATE_SPS_6);
        endcase
    end

    // start bit honoured only when idle
    assign ss_request = word_ok && shift_in_next[acr_pkg::BIT_START] &&
                        ctrl_reg.single_shot_mode && (cnv_state_reg == acr_pkg::CNV_IDLE);

    // continuous runs back to back, single-shot idles
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnv_state_reg <= acr_pkg::CNV_IDLE;
            cnv_cnt_reg   <= '0;
        end else begin
            case (cnv_state_reg)
                acr_pkg::CNV_IDLE: begin
                    cnv_cnt_reg <= '0;
                    if (ss_request || !ctrl_reg.single_shot_mode) begin
                        cnv_state_reg <= acr_pkg::CNV_RUN;
                    end
                end
                acr_pkg::CNV_RUN: begin
                    if (cnv_cnt_reg >= cnv_len - acr_pkg::CNV_W'(1)) begin
                        cnv_cnt_reg <= '0;
                        if (ctrl_reg.single_shot_mode) begin
                            cnv_state_reg <= acr_pkg::CNV_IDLE;
                        end
                    end else begin
                        cnv_cnt_reg <= cnv_cnt_reg + acr_pkg::CNV_W'(1);
                    end
                end
                default: cnv_state_reg <= acr_pkg::CNV_IDLE;
            endcase
        end
    end

    assign cnv_busy = (cnv_state_reg == acr_pkg::CNV_RUN);

    logic cnv_end;
    assign cnv_end = cnv_busy && (cnv_cnt_reg >= cnv_len - acr_pkg::CNV_W'(1));

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            CONVERSION_START <= 1'b0;
            RESULT_READY     <= 1'b0;
        end else begin
            CONVERSION_START <= ss_request ||
                                (!cnv_busy && !ctrl_reg.single_shot_mode) ||
                                (cnv_end && !ctrl_reg.single_shot_mode);
            RESULT_READY     <= cnv_end;
        end
    end

    // ---------------------------------------------------------------
    // result buffer and serial output
    // ---------------------------------------------------------------
    logic [15:0] result_reg;
    logic [31:0] shift_out_reg;
    logic [15:0] cfg_word;

    assign cfg_word = {1'b0, ctrl_reg.input_pair, ctrl_reg.gain_range_select,
                       ctrl_reg.single_shot_mode, ctrl_reg.sample_rate_select,
                       ctrl_reg.temp_sense_select, ctrl_reg.pullup_enable,
                       qual_reg, resv_reg};

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            result_reg   <= '0;
            new_data_reg <= 1'b0;
        end else begin
            if (cnv_end) begin
                result_reg   <= {RESULT_DATA, 4'h0};
                new_data_reg <= 1'b1;
            end else if (sclk_rise && bitcnt_reg == acr_pkg::BITCNT_W0) begin
                new_data_reg <= 1'b0;
            end
        end
    end

    // result then config readback, msb first on rising edges
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            shift_out_reg <= '0;
        end else if (sclk_rise) begin
            shift_out_reg <= {shift_out_reg[30:0], 1'b0};
        end else if (word_ok) begin
            // second half echoes the word just applied
            shift_out_reg <= {1'b0, shift_in_next[14:0], 16'h0};
        end else if (link_s.cs_n || (bitcnt_reg == acr_pkg::BITCNT_W0 && !sclk_d_reg)) begin
            shift_out_reg <= {result_reg, cfg_word};
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            DATA_OUT_READY_N_O    <= 1'b1;
            DATA_OUT_READY_N_OE_N <= 1'b1;
            PULLUP_ON             <= 1'b0;
        end else begin
            DATA_OUT_READY_N_OE_N <= link_s.cs_n;
            // msb leaves on the first rise, ready flag shown before it
            if (sclk_rise) begin
                DATA_OUT_READY_N_O <= shift_out_reg[31];
            end else if (bitcnt_reg == acr_pkg::BITCNT_W0 && !sclk_d_reg) begin
                DATA_OUT_READY_N_O <= ~new_data_reg;
            end
            PULLUP_ON <= link_s.cs_n && ctrl_reg.pullup_enable;
        end
    end

    // ---------------------------------------------------------------
    // decoded controls
    // ---------------------------------------------------------------
    // input pair decode
    always_comb begin
        case (ctrl_reg.input_pair)
            3'h0:    begin POSITIVE_INPUT = 2'h0; NEGATIVE_INPUT = 3'h1; end
            3'h1:    begin POSITIVE_INPUT = 2'h0; NEGATIVE_INPUT = 3'h3; end
            3'h2:    begin POSITIVE_INPUT = 2'h1; NEGATIVE_INPUT = 3'h3; end
            3'h3:    begin POSITIVE_INPUT = 2'h2; NEGATIVE_INPUT = 3'h3; end
            default: begin
                POSITIVE_INPUT = ctrl_reg.input_pair[1:0];
                NEGATIVE_INPUT = acr_pkg::MUX_SE_BASE;
            end
        endcase
    end

    // codes above 100 all give 0.256 range
    assign GAIN_RANGE_SELECT = (ctrl_reg.gain_range_select > acr_pkg::GAIN_MAX) ?
                               acr_pkg::GAIN_MAX : ctrl_reg.gain_range_select;
    assign INPUT_PAIR         = ctrl_reg.input_pair;
    assign CONTINUOUS_MODE    = ~ctrl_reg.single_shot_mode;
    assign POWERED_DOWN       = ctrl_reg.single_shot_mode & ~cnv_busy;
    assign SAMPLE_RATE_SELECT = ctrl_reg.sample_rate_select;
    assign TEMP_SENSE_SELECT  = ctrl_reg.temp_sense_select;
    assign CONFIG_READBACK    = cfg_word;
endmodule

// ===== test/acr_top_sva.sv
// assertion checker for the configuration register block
`timescale 1ns/10ps
module acr_top_sva (
    input wire logic        CORE_CLK,
    input wire logic        RESETN,
    input wire logic        CS_N,
    input wire logic        DATA_OUT_READY_N_OE_N,
    input wire logic        PULLUP_ON,
    input wire logic [2:0]  INPUT_PAIR,
    input wire logic [1:0]  POSITIVE_INPUT,
    input wire logic [2:0]  NEGATIVE_INPUT,
    input wire logic [2:0]  GAIN_RANGE_SELECT,
    input wire logic        CONTINUOUS_MODE,
    input wire logic        POWERED_DOWN,
    input wire logic [2:0]  SAMPLE_RATE_SELECT,
    input wire logic        TEMP_SENSE_SELECT,
    input wire logic        CONVERSION_START,
    input wire logic [15:0] CONFIG_READBACK
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    logic [2:0] mux;
    logic [2:0] gf;
    assign mux = CONFIG_READBACK[14:12];
    assign gf  = CONFIG_READBACK[11:9];
    sequence s_settled; $stable(CONFIG_READBACK) [*3]; endsequence
    sequence s_cs_high; CS_N [*8]; endsequence
    sequence s_cs_low; !CS_N [*8]; endsequence
    AST_START_READS_ZERO: assert property (CONFIG_READBACK[15] == 1'b0)
        else $error("start bit read back as one");
    AST_QUAL_ALWAYS_VALID: assert property (CONFIG_READBACK[2:1] == 2'h1)
        else $error("qualifier field not valid code");
    AST_MUX_DECODE: assert property (s_settled |-> INPUT_PAIR == mux
        && POSITIVE_INPUT == (mux[2] | mux[1:0] == 2'h0 ? mux[1:0] : mux[1:0] - 2'h1)
        && NEGATIVE_INPUT == (mux[2] ? 3'h4 : (mux[1:0] == 2'h0 ? 3'h1 : 3'h3)))
        else $error("input pair decode wrong");
    AST_GAIN_DECODE: assert property (
        s_settled |-> GAIN_RANGE_SELECT == (gf > 3'h5 ? 3'h5 : gf))
        else $error("gain range decode wrong");
    AST_MODE_DECODE: assert property (s_settled |->
        CONTINUOUS_MODE == !CONFIG_READBACK[8] && (!POWERED_DOWN || CONFIG_READBACK[8]))
        else $error("mode outputs wrong");
    AST_RATE_DECODE: assert property (
        s_settled |-> SAMPLE_RATE_SELECT == CONFIG_READBACK[7:5])
        else $error("sample rate wrong");
    AST_TSENSE_DECODE: assert property (
        s_settled |-> TEMP_SENSE_SELECT == CONFIG_READBACK[4])
        else $error("temp sense select wrong");
    AST_PULLUP_IDLE: assert property (
        s_cs_high |-> PULLUP_ON == CONFIG_READBACK[3] && DATA_OUT_READY_N_OE_N)
        else $error("pull-up or enable wrong while deselected");
    AST_DRIVE_SELECTED: assert property (
        s_cs_low |-> !PULLUP_ON && !DATA_OUT_READY_N_OE_N)
        else $error("pin not driven while selected");
    AST_WRITE_IN_FRAME: assert property (
        $changed(CONFIG_READBACK) |-> !$past(CS_N, 3))
        else $error("config changed outside a frame");
    AST_START_PULSE: assert property (CONVERSION_START |=> !CONVERSION_START)
        else $error("start pulse longer than one cycle");
endmodule

// ===== test/acr_host_model.sv
// link host model, clock idles low, 125 ns period
`timescale 1ns/10ps
module acr_host_model (
    input wire logic clk,
    input wire logic miso,
    output logic     sclk,
    output logic     cs_n,
    output logic     din
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b1;
    end
    task automatic wait_neg(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic frame(input int nbits, input logic [31:0] word, output logic [31:0] rx);
        rx = 32'h0;
        @(negedge clk);
        cs_n = 1'b0;
        wait_neg(12);
        for (int i = 0; i < nbits; i++) begin
            sclk = 1'b1;
            din  = word[31-i];
            wait_neg(13);
            sclk = 1'b0;
            rx   = {rx[30:0], miso};
            wait_neg(12);
        end
        cs_n = 1'b1;
        din  = ~din;
    endtask
endmodule

// ===== test/tb_adc_config_register.sv
// self-checking bench for the configuration register block
`timescale 1ns/10ps
module tb_adc_config_register;
    logic        core_clk, resetn, sclk, cs_n, din, dout, dout_oe_n, pullup_on;
    logic        cont_mode, pwr_down, ts_sel, cnv_start, cnv_rdy;
    logic [11:0] result_data;
    logic [2:0]  in_pair, neg_in, gain, rate;
    logic [1:0]  pos_in;
    logic [15:0] cfg_rb, w, exp;
    logic [31:0] r, rx;
    logic [31:0] seed = 32'h32;
    wire         pin;
    int          failures = 0;
    int          cmp_count = 0;
    int          starts = 0;
    assign pin = !dout_oe_n ? dout : (pullup_on ? 1'b1 : 1'bz);
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (cnv_start === 1'b1) starts++;
    acr_top u_acr_top (
        .CORE_CLK(core_clk), .RESETN(resetn), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
        .RESULT_DATA(result_data), .DATA_OUT_READY_N_O(dout),
        .DATA_OUT_READY_N_OE_N(dout_oe_n), .PULLUP_ON(pullup_on), .INPUT_PAIR(in_pair),
        .POSITIVE_INPUT(pos_in), .NEGATIVE_INPUT(neg_in), .GAIN_RANGE_SELECT(gain),
        .CONTINUOUS_MODE(cont_mode), .POWERED_DOWN(pwr_down), .SAMPLE_RATE_SELECT(rate),
        .TEMP_SENSE_SELECT(ts_sel), .CONVERSION_START(cnv_start), .RESULT_READY(cnv_rdy),
        .CONFIG_READBACK(cfg_rb)
    );
    acr_host_model u_acr_host_model (
        .clk(core_clk), .miso(pin), .sclk(sclk), .cs_n(cs_n), .din(din)
    );
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [4:0] exp_mux(input logic [2:0] c);
        if (c[2]) return {c[1:0], 3'h4};
        if (c == 3'h0) return {2'h0, 3'h1};
        return {c[1:0] - 2'h1, 3'h3};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] e, input string what);
        cmp_count++;
        if (got !== e) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, e);
        end
    endtask
    task automatic send(input int n, input logic [31:0] word);
        result_data = r[27:16];
        u_acr_host_model.frame(n, word, rx);
        repeat (8) @(negedge core_clk);
    endtask
    task automatic check_all(input logic [15:0] e);
        check(cfg_rb, e, "readback");
        check({11'h0, pos_in, neg_in}, {11'h0, exp_mux(e[14:12])}, "mux");
        check({13'h0, in_pair}, {13'h0, e[14:12]}, "pair");
        check({13'h0, gain}, {13'h0, e[11:9] > 3'h5 ? 3'h5 : e[11:9]}, "gain");
        check({15'h0, cont_mode}, {15'h0, ~e[8]}, "mode");
        check({13'h0, rate}, {13'h0, e[7:5]}, "rate");
        check({15'h0, ts_sel}, {15'h0, e[4]}, "tsense");
        check({15'h0, pullup_on}, {15'h0, e[3]}, "pullup");
    endtask
    task automatic conclude();
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        result_data = 12'h0;
        r = 32'h0;
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        repeat (8) @(negedge core_clk);
        check_all(16'h058b);
        check({15'h0, pwr_down}, 16'h1, "idle");
        w = 16'h85cb;
        send(32, {w, w});
        exp = 16'h05cb;
        check(rx[15:0], exp, "start echo");
        check_all(exp);
        check(starts[15:0], 16'h1, "one start");
        check({15'h0, pwr_down}, 16'h0, "busy");
        send(32, {w, w});
        check(starts[15:0], 16'h1, "start while busy");
        r = xs();
        result_data = r[27:16];
        for (int t = 0; t < 70000 && cnv_rdy !== 1'b1; t++) @(negedge core_clk);
        if (cnv_rdy !== 1'b1) begin
            failures++;
            $display("[ERR] %0t conversion never finished", $time);
        end
        repeat (2) @(negedge core_clk);
        check({15'h0, dout}, 16'h0, "ready low");
        check({15'h0, pwr_down}, 16'h1, "back to idle");
        send(32, 32'h0);
        check(rx[31:16], {r[27:16], 4'h0}, "result");
        check(rx[15:0], exp, "idle echo");
        check({15'h0, dout}, 16'h1, "ready cleared");
        for (int k = 0; k < 13; k++) begin
            r = xs();
            w = (k == 0) ? 16'h7ef3 : {1'b0, r[14:3], 3'h3};
            send(32, {w, w});
            exp = w;
            check(rx[15:0], exp, "echo");
            check_all(exp);
        end
        for (int q = 0; q < 4; q++) begin
            if (q == 1) continue;
            r = xs();
            w = {1'b0, r[14:3], q[1:0], 1'b1};
            send(32, {w, w});
            check(rx[15:0], exp, "nop echo");
            check_all(exp);
        end
        send(32, 32'h0);
        check_all(exp);
        send(32, 32'hffffffff);
        check_all(exp);
        r = xs();
        w = {1'b0, r[14:3], 3'h3};
        send(10, {w, 16'h0});
        check_all(exp);
        send(32, {w, w});
        exp = w;
        check_all(exp);
        conclude();
    end
endmodule
bind acr_top acr_top_sva u_acr_top_sva (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .CS_N(CS_N),
    .DATA_OUT_READY_N_OE_N(DATA_OUT_READY_N_OE_N), .PULLUP_ON(PULLUP_ON),
    .INPUT_PAIR(INPUT_PAIR), .POSITIVE_INPUT(POSITIVE_INPUT),
    .NEGATIVE_INPUT(NEGATIVE_INPUT), .GAIN_RANGE_SELECT(GAIN_RANGE_SELECT),
    .CONTINUOUS_MODE(CONTINUOUS_MODE), .POWERED_DOWN(POWERED_DOWN),
    .SAMPLE_RATE_SELECT(SAMPLE_RATE_SELECT), .TEMP_SENSE_SELECT(TEMP_SENSE_SELECT),
    .CONVERSION_START(CONVERSION_START), .CONFIG_READBACK(CONFIG_READBACK)
);
